// file: hw/port_pin_regs.svh
// Offsets, field positions and reset values for the port and pin function block
// Assumes an 8-bit register port with a 5-bit address and read data one cycle late
`ifndef PORT_PIN_REGS_SVH
`define PORT_PIN_REGS_SVH

`define GRP_LATCH 2'h0
`define GRP_MODE 2'h1
`define GRP_PULL 2'h2
`define IDX_UNMAPPED 3'h7
`define REG_EDGE_RISE 5'h18
`define REG_EDGE_FALL 5'h19
`define REG_FLAGS 5'h1A
`define REG_FUNC_SEL 5'h1B
`define REG_ANALOG_SEL 5'h1C
`define REG_CLK_CTRL 5'h1D
`define REG_STATUS 5'h1E

`define FSEL_EXT_MEM 0
`define FSEL_AUTO_XFER 1
`define FSEL_PWM 2
`define FSEL_SB0 3
`define FSEL_TMR_OUT 5
`define FSEL_CLK_OUT 6
`define FSEL_TONE 7
`define CLK_FB_CUT_BIT 6
`define FLAG_FALL_BIT 4

`define PORT0_IO_MASK 8'h0E
`define PORT0_BITS_MASK 8'h1F
`define PM_RESET 8'hFF
`define P2_STB_BIT 3
`define P2_BUSY_BIT 4
`define P2_SB_BIT 5
`define P3_CLK_BIT 5
`define P3_TONE_BIT 6
`define P6_RD_BIT 4
`define P6_WR_BIT 5
`define P6_WAIT_BIT 6
`define P6_ADDR_LATCH_STROBE_BIT 7
`define VPP_NONE 2'h0

`endif

// file: hw/port_pin_pkg.sv
// Types shared by the port and pin function block
// Assumes the constants header is included beside it
package port_pin_pkg;
  // Drive of one 8-bit pin group; oe_n low drives
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } pin8_s;
  // External memory request
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_s;
  // Outputs of internal peripherals toward the pins
  typedef struct packed {
    logic [2:0] timer_out;
    logic pwm_out;
    logic clk_out;
    logic tone_out;
    logic auto_strobe;
    logic [1:0] sb_dout;
    logic [1:0] sb_oe;
  } alt_out_s;
  // Pin levels handed to internal peripherals
  typedef struct packed {
    logic [3:0] ext_irq;
    logic [2:0] timer_count_in;
    logic [1:0] sb_din;
    logic auto_busy;
  } alt_in_s;
  // Programming mode controls
  typedef struct packed {
    logic select;
    logic prog_pulse;
    logic read_strobe;
    logic inhibit;
  } prom_ctl_s;
  // External access sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_STRB = 4'b0100,
    ST_END = 4'b1000
  } mem_state_e;
endpackage : port_pin_pkg

// file: hw/port_pin_function_mux.sv
// Port latches, directions, pull-ups and alternate pin functions
// Assumes synchronous pin inputs, one clock, peripherals supply alt outputs
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "port_pin_regs.svh"

module port_pin_function_mux (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Port pins, ports zero to six
  input wire logic [7:0] i_port_pin [7],
  output port_pin_pkg::pin8_s o_port_pin [7],
  output logic [7:0] o_pullup_en [7],
  // Programming mode pins
  input wire logic [1:0] i_vpp_level,
  input wire logic i_reset_pin_n,
  input wire logic i_prom_ce_n,
  input wire logic i_prom_oe_n,
  input wire logic i_prom_pgm_n,
  output logic o_prog_mode,
  output port_pin_pkg::prom_ctl_s o_prom_ctl,
  // External memory request
  input wire logic i_mem_req,
  input port_pin_pkg::mem_req_s i_mem_cmd,
  output logic o_mem_busy,
  output logic o_mem_done,
  output logic [7:0] o_mem_rdata,
  // Peripheral side
  input port_pin_pkg::alt_out_s i_alt,
  output port_pin_pkg::alt_in_s o_alt,
  output logic [7:0] o_analog_sel,
  output logic o_sub_osc_fb_cut
);

  logic [7:0] latch_q [7];
  logic [7:0] pm_q [7];
  logic [7:0] pu_q [7];
  logic [7:0] rise_q;
  logic [7:0] fall_q;
  logic [7:0] flags_q;
  logic [7:0] fsel_q;
  logic [7:0] analog_q;
  logic [7:0] clkc_q;
  logic [7:0] p0_prev_q;
  logic [7:0] p4_prev_q;
  logic prog_q;
  logic prog_d;
  port_pin_pkg::mem_state_e state_q;
  port_pin_pkg::mem_state_e state_d;
  port_pin_pkg::mem_req_s cmd_q;
  port_pin_pkg::mem_req_s cmd_d;
  port_pin_pkg::pin8_s pin_d [7];
  logic [7:0] pin_val [7];
  logic [7:0] pu_d [7];
  logic [2:0] idx;
  logic ext_en;
  logic wait_act;
  logic [3:0] irq_ev;
  logic fall4_ev;
  logic [7:0] p0_cur;

  assign idx = i_reg_addr[2:0];
  assign ext_en = fsel_q[`FSEL_EXT_MEM] & ~prog_q;
  assign wait_act = ext_en & ~i_port_pin[6][`P6_WAIT_BIT];
  assign p0_cur = i_port_pin[0];
  assign o_prog_mode = prog_q;
  assign o_analog_sel = analog_q;
  assign o_sub_osc_fb_cut = clkc_q[`CLK_FB_CUT_BIT];

  // Readback value: pin level for inputs, latch for outputs
  genvar gp;
  generate
    for (gp = 0; gp < 7; gp++) begin : g_port
      if (gp == 0) begin : g_p0
        // Sub oscillator pin reads as zero until the feedback is cut
        assign pin_val[gp] = ((i_port_pin[gp] & pm_q[gp]) | (latch_q[gp] & ~pm_q[gp]))
                             & {3'h0, clkc_q[`CLK_FB_CUT_BIT], 4'hF}
                             & `PORT0_BITS_MASK;
      end else begin : g_pn
        assign pin_val[gp] = (i_port_pin[gp] & pm_q[gp]) | (latch_q[gp] & ~pm_q[gp]);
      end
    end
  endgenerate

  // Port latch, direction and pull-up registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int p = 0; p < 7; p++) begin
        latch_q[p] <= 8'h00;
        pm_q[p] <= `PM_RESET;
        pu_q[p] <= 8'h00;
      end
    end else if (i_reg_wr && idx != `IDX_UNMAPPED) begin
      case (i_reg_addr[4:3])
        `GRP_LATCH: latch_q[idx] <= i_reg_wdata;
        `GRP_MODE: begin
          if (idx == 3'h0) begin
            pm_q[0] <= i_reg_wdata | ~`PORT0_IO_MASK;
          end else if (idx == 3'h4) begin
            pm_q[4] <= {8{i_reg_wdata[0]}};
          end else begin
            pm_q[idx] <= i_reg_wdata;
          end
        end
        `GRP_PULL: begin
          if (idx == 3'h0) begin
            pu_q[0] <= i_reg_wdata & `PORT0_BITS_MASK;
          end else begin
            pu_q[idx] <= i_reg_wdata;
          end
        end
        default: ;
      endcase
    end
  end

  // Edge select, function select, analog select and clock control
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rise_q <= 8'h00;
      fall_q <= 8'h00;
      fsel_q <= 8'h00;
      analog_q <= 8'h00;
      clkc_q <= 8'h00;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_EDGE_RISE: rise_q <= i_reg_wdata & 8'h07;
        `REG_EDGE_FALL: fall_q <= i_reg_wdata & 8'h07;
        `REG_FUNC_SEL: fsel_q <= i_reg_wdata;
        `REG_ANALOG_SEL: analog_q <= i_reg_wdata;
        `REG_CLK_CTRL: clkc_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Edge events on interrupt pins and port four
  always_comb begin
    irq_ev[2:0] = (p0_cur[2:0] & ~p0_prev_q[2:0] & rise_q[2:0])
                | (~p0_cur[2:0] & p0_prev_q[2:0] & fall_q[2:0]);
    irq_ev[3] = ~p0_cur[3] & p0_prev_q[3];
    fall4_ev = (|(~i_port_pin[4] & p4_prev_q)) & ~ext_en & pm_q[4][0];
  end

  // Previous pin samples; zero at reset so no false fall appears
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      p0_prev_q <= 8'h00;
      p4_prev_q <= 8'h00;
    end else begin
      p0_prev_q <= p0_cur;
      p4_prev_q <= i_port_pin[4];
    end
  end

  // Sticky event flags, write one to clear, a new event wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= (flags_q & ~((i_reg_wr && i_reg_addr == `REG_FLAGS) ? i_reg_wdata : 8'h00))
               | {3'h0, fall4_ev, irq_ev};
    end
  end

  // Register read, data valid the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= 8'h00;
      if (idx != `IDX_UNMAPPED && i_reg_addr[4:3] == `GRP_LATCH) begin
        o_reg_rdata <= pin_val[idx];
      end else if (idx != `IDX_UNMAPPED && i_reg_addr[4:3] == `GRP_MODE) begin
        o_reg_rdata <= pm_q[idx];
      end else if (idx != `IDX_UNMAPPED && i_reg_addr[4:3] == `GRP_PULL) begin
        o_reg_rdata <= pu_q[idx];
      end else begin
        case (i_reg_addr)
          `REG_EDGE_RISE: o_reg_rdata <= rise_q;
          `REG_EDGE_FALL: o_reg_rdata <= fall_q;
          `REG_FLAGS: o_reg_rdata <= flags_q;
          `REG_FUNC_SEL: o_reg_rdata <= fsel_q;
          `REG_ANALOG_SEL: o_reg_rdata <= analog_q;
          `REG_CLK_CTRL: o_reg_rdata <= clkc_q;
          `REG_STATUS: o_reg_rdata <= {5'h00, wait_act, state_q != port_pin_pkg::ST_IDLE, prog_q};
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // External access sequencer
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    case (state_q)
      port_pin_pkg::ST_IDLE: begin
        if (ext_en && i_mem_req) begin
          state_d = port_pin_pkg::ST_ADDR;
          cmd_d = i_mem_cmd;
        end
      end
      port_pin_pkg::ST_ADDR: state_d = port_pin_pkg::ST_STRB;
      port_pin_pkg::ST_STRB: begin
        if (!wait_act) begin
          state_d = port_pin_pkg::ST_END;
        end
      end
      port_pin_pkg::ST_END: state_d = port_pin_pkg::ST_IDLE;
      default: state_d = port_pin_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state, read capture and handshake outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= port_pin_pkg::ST_IDLE;
      cmd_q <= '0;
      o_mem_rdata <= 8'h00;
      o_mem_done <= 1'b0;
      o_mem_busy <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      o_mem_done <= state_d == port_pin_pkg::ST_END;
      o_mem_busy <= state_d != port_pin_pkg::ST_IDLE;
      if (state_q == port_pin_pkg::ST_STRB && !wait_act && !cmd_q.we) begin
        o_mem_rdata <= i_port_pin[4];
      end
    end
  end

  // Pin drive: port latches first, alternate functions on top
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      pin_d[p].dout = latch_q[p];
      pin_d[p].oe_n = pm_q[p];
    end
    pin_d[0].oe_n = pm_q[0] | ~`PORT0_IO_MASK;
    if (fsel_q[`FSEL_AUTO_XFER]) begin
      pin_d[2].dout[`P2_STB_BIT] = i_alt.auto_strobe;
      pin_d[2].oe_n[`P2_STB_BIT] = 1'b0;
      pin_d[2].oe_n[`P2_BUSY_BIT] = 1'b1;
    end
    for (int k = 0; k < 2; k++) begin
      if (fsel_q[`FSEL_SB0 + k]) begin
        pin_d[2].dout[`P2_SB_BIT + k] = i_alt.sb_dout[k];
        pin_d[2].oe_n[`P2_SB_BIT + k] = ~i_alt.sb_oe[k];
      end
    end
    if (fsel_q[`FSEL_TMR_OUT]) begin
      pin_d[3].dout[0] = fsel_q[`FSEL_PWM] ? i_alt.pwm_out : i_alt.timer_out[0];
      pin_d[3].dout[2:1] = i_alt.timer_out[2:1];
      pin_d[3].oe_n[2:0] = 3'h0;
    end
    if (fsel_q[`FSEL_CLK_OUT]) begin
      pin_d[3].dout[`P3_CLK_BIT] = i_alt.clk_out;
      pin_d[3].oe_n[`P3_CLK_BIT] = 1'b0;
    end
    if (fsel_q[`FSEL_TONE]) begin
      pin_d[3].dout[`P3_TONE_BIT] = i_alt.tone_out;
      pin_d[3].oe_n[`P3_TONE_BIT] = 1'b0;
    end
    if (ext_en) begin
      pin_d[5].dout = cmd_d.addr[15:8];
      pin_d[5].oe_n = 8'h00;
      pin_d[4].oe_n = 8'hFF;
      if (state_d == port_pin_pkg::ST_ADDR) begin
        pin_d[4].dout = cmd_d.addr[7:0];
        pin_d[4].oe_n = 8'h00;
      end else if (state_d == port_pin_pkg::ST_STRB && cmd_d.we) begin
        pin_d[4].dout = cmd_d.wdata;
        pin_d[4].oe_n = 8'h00;
      end
      pin_d[6].dout[`P6_RD_BIT] = ~(state_d == port_pin_pkg::ST_STRB && !cmd_d.we);
      pin_d[6].dout[`P6_WR_BIT] = ~(state_d == port_pin_pkg::ST_STRB && cmd_d.we);
      pin_d[6].dout[`P6_ADDR_LATCH_STROBE_BIT] = state_d == port_pin_pkg::ST_ADDR;
      pin_d[6].oe_n[`P6_RD_BIT] = 1'b0;
      pin_d[6].oe_n[`P6_WR_BIT] = 1'b0;
      pin_d[6].oe_n[`P6_ADDR_LATCH_STROBE_BIT] = 1'b0;
      pin_d[6].oe_n[`P6_WAIT_BIT] = 1'b1;
    end
    if (prog_q) begin
      for (int p = 0; p < 7; p++) begin
        pin_d[p].oe_n = 8'hFF;
      end
    end
    for (int p = 0; p < 7; p++) begin
      pu_d[p] = pu_q[p] & pin_d[p].oe_n;
    end
    pu_d[1] = pu_d[1] & ~analog_q;
  end

  // Registered pin drive and pull-up enables
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int p = 0; p < 7; p++) begin
        o_port_pin[p] <= '{dout: 8'h00, oe_n: 8'hFF};
        o_pullup_en[p] <= 8'h00;
      end
    end else begin
      o_port_pin <= pin_d;
      o_pullup_en <= pu_d;
    end
  end

  // Pin levels toward timers, serial units and interrupt logic
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_alt <= '0;
    end else begin
      o_alt.ext_irq <= irq_ev;
      o_alt.timer_count_in <= {i_port_pin[3][4], i_port_pin[3][3], p0_cur[0]};
      o_alt.sb_din <= i_port_pin[2][6:5];
      o_alt.auto_busy <= fsel_q[`FSEL_AUTO_XFER] & i_port_pin[2][`P2_BUSY_BIT];
    end
  end

  // Programming mode entry and programming controls
  assign prog_d = (i_vpp_level != `VPP_NONE) & ~i_reset_pin_n;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prog_q <= 1'b0;
      o_prom_ctl <= '0;
    end else begin
      prog_q <= prog_d;
      o_prom_ctl.select <= prog_d & ~i_prom_ce_n;
      o_prom_ctl.prog_pulse <= prog_d & ~i_prom_ce_n & i_prom_oe_n & ~i_prom_pgm_n;
      o_prom_ctl.read_strobe <= prog_d & ~i_prom_oe_n;
      o_prom_ctl.inhibit <= prog_d & ~i_prom_pgm_n & ~i_prom_oe_n | prog_d & i_prom_pgm_n & i_prom_oe_n;
    end
  end

  // Checks on the pin logic
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_port0_outer_in: assert property (o_port_pin[0].oe_n[0] && o_port_pin[0].oe_n[4])
    else $error("port zero outer bit driven");
  a_port4_whole_dir: assert property (o_port_pin[4].oe_n == 8'h00 || o_port_pin[4].oe_n == 8'hFF)
    else $error("port four direction split");
  a_fall_sets_flag: assert property (fall4_ev |=> flags_q[`FLAG_FALL_BIT])
    else $error("port four fall flag not set");
  a_analog_pullup_off: assert property ((o_pullup_en[1] & $past(analog_q)) == 8'h00)
    else $error("pull-up on analog pin");
  a_irq_fall_edge: assert property ((!p0_cur[0] && p0_prev_q[0] && fall_q[0]) |=> o_alt.ext_irq[0])
    else $error("selected falling edge missed");
  a_irq3_no_rise: assert property ((p0_cur[3] && !p0_prev_q[3]) |=> !o_alt.ext_irq[3])
    else $error("fourth interrupt on rising edge");
  a_addr_then_strb: assert property ((state_q == port_pin_pkg::ST_ADDR) |->
    o_port_pin[6].dout[`P6_ADDR_LATCH_STROBE_BIT] && o_port_pin[4].oe_n == 8'h00 ##1
    !o_port_pin[6].dout[`P6_ADDR_LATCH_STROBE_BIT] && !(o_port_pin[6].dout[`P6_RD_BIT] && o_port_pin[6].dout[`P6_WR_BIT]))
    else $error("address strobe order broken");
  a_high_addr_out: assert property ((ext_en && state_q == port_pin_pkg::ST_ADDR) |->
    o_port_pin[5].oe_n == 8'h00 && o_port_pin[5].dout == cmd_q.addr[15:8])
    else $error("high address not driven");
  a_wait_stretch: assert property ((state_q == port_pin_pkg::ST_STRB && wait_act) |=> state_q == port_pin_pkg::ST_STRB)
    else $error("wait ignored");
  a_prog_entry: assert property ((i_vpp_level != `VPP_NONE && !i_reset_pin_n) |=> o_prog_mode)
    else $error("programming mode not entered");

  c_ext_read: cover property (state_q == port_pin_pkg::ST_STRB && !cmd_q.we ##1 state_q == port_pin_pkg::ST_END);
  c_ext_write: cover property (state_q == port_pin_pkg::ST_STRB && cmd_q.we ##1 state_q == port_pin_pkg::ST_END);
  c_wait_seen: cover property (state_q == port_pin_pkg::ST_STRB && wait_act ##1 state_q == port_pin_pkg::ST_STRB);
  c_fall_flag: cover property (fall4_ev);

endmodule : port_pin_function_mux

// file: testbench/ext_mem_model.sv
// External memory that sits on ports four, five and six during expansion
// Assumes the block drives the strobes as registered pins; the bench sets the wait length
`timescale 1ns/10ps
`include "port_pin_regs.svh"

module ext_mem_model (
  // Clock
  input wire logic i_ref_clk,
  // Pins as the block drives them
  input port_pin_pkg::pin8_s i_p4,
  input port_pin_pkg::pin8_s i_p5,
  input port_pin_pkg::pin8_s i_p6,
  input wire logic [3:0] i_wait_cycles,
  // Pins toward the block
  output logic [7:0] o_bus,
  output logic o_wait_n
);
  logic [7:0] mem [65536];
  logic [15:0] addr_q = 16'h0000;
  logic [7:0] last_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic rd_n, wr_n, addr_latch_strobe;

  // Strobes count only while the block really drives them
  assign rd_n = i_p6.oe_n[`P6_RD_BIT] | i_p6.dout[`P6_RD_BIT];
  assign wr_n = i_p6.oe_n[`P6_WR_BIT] | i_p6.dout[`P6_WR_BIT];
  assign addr_latch_strobe = ~i_p6.oe_n[`P6_ADDR_LATCH_STROBE_BIT] & i_p6.dout[`P6_ADDR_LATCH_STROBE_BIT];
  // Wait held low for the asked number of strobe cycles
  assign o_wait_n = !((!rd_n || !wr_n) && cnt_q < i_wait_cycles);
  // Read data while the read strobe is low, a changing pattern once released
  assign o_bus = !rd_n ? mem[addr_q] : ~last_q;

  // Address capture on the latch strobe, write capture on the write strobe
  always @(posedge i_ref_clk) begin
    if (addr_latch_strobe) begin
      addr_q <= {i_p5.dout, i_p4.dout};
      cnt_q <= 4'h0;
    end else if (!o_wait_n) begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (!wr_n) begin
      mem[addr_q] <= i_p4.dout;
    end
    last_q <= o_bus;
  end
endmodule : ext_mem_model

// file: testbench/port_pin_function_mux_tb.sv
// Self-checking bench for the port and pin function block
// Assumes the external memory model on ports four to six; other pins are driven here
`timescale 1ns/10ps
`include "port_pin_regs.svh"
`define CMP(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); end end

module port_pin_function_mux_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata, mem_rdata, ana_sel, m_bus, v, a, mv;
  logic [7:0] ext [7] = '{default: 8'h00};
  logic [7:0] pins [7];
  logic [7:0] pull [7];
  logic [7:0] pu [7];
  port_pin_pkg::pin8_s pout [7];
  logic [1:0] vpp = 2'h0;
  logic rst_pin_n = 1'b1;
  logic pr_ce_n = 1'b1;
  logic pr_oe_n = 1'b1;
  logic pr_pgm_n = 1'b1;
  logic prog, mem_busy, mem_done, fb_cut, m_wait_n, c, o, g;
  port_pin_pkg::prom_ctl_s prom, pe;
  logic mem_req = 1'b0;
  port_pin_pkg::mem_req_s mem_cmd = '0;
  port_pin_pkg::alt_out_s alt = '0;
  port_pin_pkg::alt_in_s alt_in;
  logic use_mem = 1'b0;
  logic rd_pend = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  logic [7:0] rd_q [$];
  logic [8:0] mem_q [$];
  int bad_count = 0;
  int checks = 0;
  int n;

  always #12.5 i_ref_clk = ~i_ref_clk;

  // Pin level: block output where it drives, else the outside party
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      pins[p] = (pout[p].dout & ~pout[p].oe_n) | (ext[p] & pout[p].oe_n);
    end
    if (use_mem) begin
      pins[4] = (pout[4].dout & ~pout[4].oe_n) | (m_bus & pout[4].oe_n);
      pins[6][`P6_WAIT_BIT] = m_wait_n;
    end
  end

  port_pin_function_mux dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(rdata), .i_port_pin(pins), .o_port_pin(pout), .o_pullup_en(pull),
    .i_vpp_level(vpp), .i_reset_pin_n(rst_pin_n), .i_prom_ce_n(pr_ce_n), .i_prom_oe_n(pr_oe_n),
    .i_prom_pgm_n(pr_pgm_n), .o_prog_mode(prog), .o_prom_ctl(prom),
    .i_mem_req(mem_req), .i_mem_cmd(mem_cmd), .o_mem_busy(mem_busy), .o_mem_done(mem_done),
    .o_mem_rdata(mem_rdata), .i_alt(alt), .o_alt(alt_in), .o_analog_sel(ana_sel), .o_sub_osc_fb_cut(fb_cut)
  );

  ext_mem_model mem_u (
    .i_ref_clk(i_ref_clk), .i_p4(pout[4]), .i_p5(pout[5]), .i_p6(pout[6]),
    .i_wait_cycles(wait_cyc), .o_bus(m_bus), .o_wait_n(m_wait_n)
  );

  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    @(posedge i_ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge i_ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] ad, input logic [7:0] e);
    @(posedge i_ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    rd_q.push_back(e);
    @(posedge i_ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic settle();
    repeat (2) @(negedge i_ref_clk);
  endtask : settle

  task automatic mem_op(input logic we, input logic [15:0] ad, input logic [7:0] d, input logic [3:0] w);
    int cyc;
    @(posedge i_ref_clk);
    mem_req <= 1'b1;
    mem_cmd <= '{we: we, addr: ad, wdata: d};
    wait_cyc <= w;
    mem_q.push_back({!we, d});
    @(posedge i_ref_clk);
    mem_req <= 1'b0;
    cyc = 0;
    do begin
      @(negedge i_ref_clk);
      cyc++;
    end while (mem_done !== 1'b1 && cyc < 20);
    `CMP(cyc, 3 + w)
    `CMP(mem_busy, 1'b1)
  endtask : mem_op

  task automatic close_out();
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // Result watcher: register reads and external reads against the oldest note
  always @(negedge i_ref_clk) begin
    if (rd_pend) begin
      mv = rd_q.pop_front();
      `CMP(rdata, mv)
    end
    if (mem_done === 1'b1 && mem_q.size() > 0) begin
      if (mem_q[0][8]) `CMP(mem_rdata, mem_q[0][7:0])
      void'(mem_q.pop_front());
    end
    rd_pend <= reg_rd;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    close_out();
  end

  initial begin
    void'($urandom(32'hEC2BB2DC));
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    settle();
    for (n = 0; n < 7; n++) `CMP(pout[n].oe_n, 8'hFF)
    for (n = 0; n < 7; n++) rd(5'(8 + n), 8'hFF);
    // Pull-ups on input bits, analog channels never pulled
    a = 8'($urandom);
    wr(`REG_ANALOG_SEL, a);
    for (n = 0; n < 7; n++) begin
      pu[n] = 8'($urandom);
      wr(5'(16 + n), pu[n]);
    end
    settle();
    `CMP(pull[0], pu[0] & 8'h1F)
    `CMP(pull[1], pu[1] & ~a)
    `CMP(ana_sel, a)
    for (n = 2; n < 7; n++) `CMP(pull[n], pu[n])
    // Port zero input bits and the sub oscillator pin
    @(posedge i_ref_clk);
    ext[0] <= 8'h1F;
    rd(5'h00, 8'h0F);
    wr(`REG_CLK_CTRL, 8'h40);
    rd(5'h00, 8'h1F);
    `CMP(fb_cut, 1'b1)
    // Port zero outer bits stay inputs
    wr(5'h08, 8'h00);
    rd(5'h08, 8'hF1);
    settle();
    `CMP(pout[0].oe_n[4:0], 5'h11)
    `CMP(pull[0], pu[0] & 8'h11)
    wr(5'h08, 8'hFF);
    // Port four direction as one unit
    wr(5'h0C, 8'hFE);
    rd(5'h0C, 8'h00);
    wr(5'h04, 8'h5A);
    rd(5'h04, 8'h5A);
    settle();
    `CMP(pout[4].oe_n, 8'h00)
    `CMP(pout[4].dout, 8'h5A)
    wr(5'h0C, 8'h01);
    rd(5'h0C, 8'hFF);
    // Falling edge on port four
    @(posedge i_ref_clk);
    ext[4] <= 8'hFF;
    settle();
    wr(`REG_FLAGS, 8'h1F);
    @(posedge i_ref_clk);
    ext[4] <= 8'h7F;
    settle();
    rd(`REG_FLAGS, 8'h10);
    wr(`REG_FLAGS, 8'h10);
    rd(`REG_FLAGS, 8'h00);
    // Interrupt edges: rising, falling, both
    for (n = 1; n < 4; n++) begin
      wr(`REG_EDGE_RISE, n[0] ? 8'h07 : 8'h00);
      wr(`REG_EDGE_FALL, n[1] ? 8'h07 : 8'h00);
      @(posedge i_ref_clk);
      ext[0] <= 8'h00;
      settle();
      wr(`REG_FLAGS, 8'h1F);
      @(posedge i_ref_clk);
      ext[0] <= 8'h0F;
      settle();
      `CMP(alt_in.ext_irq, n[0] ? 4'h7 : 4'h0)
      rd(`REG_FLAGS, n[0] ? 8'h07 : 8'h00);
      wr(`REG_FLAGS, 8'h1F);
      @(posedge i_ref_clk);
      ext[0] <= 8'h00;
      settle();
      `CMP(alt_in.ext_irq, n[1] ? 4'hF : 4'h8)
      rd(`REG_FLAGS, n[1] ? 8'h0F : 8'h08);
    end
    // Alternate outputs and inputs
    wr(`REG_FUNC_SEL, 8'hEA);
    @(posedge i_ref_clk);
    alt <= port_pin_pkg::alt_out_s'(11'($urandom));
    ext[2] <= 8'h30;
    ext[3] <= 8'h08;
    settle();
    `CMP(pout[3].dout[2:0], alt.timer_out)
    `CMP(pout[3].oe_n[2:0], 3'h0)
    `CMP(pout[2].dout[3], alt.auto_strobe)
    `CMP(pout[3].dout[6:5], {alt.tone_out, alt.clk_out})
    `CMP(alt_in.auto_busy, 1'b1)
    // Serial input is sampled one cycle after the pin drive settles
    @(negedge i_ref_clk);
    `CMP(alt_in.sb_din[0], pins[2][5])
    `CMP(alt_in.timer_count_in, 3'h2)
    wr(`REG_FUNC_SEL, 8'h24);
    settle();
    `CMP(pout[3].dout[0], alt.pwm_out)
    // External memory with waits, back to back
    wr(`REG_FUNC_SEL, 8'h01);
    @(posedge i_ref_clk);
    use_mem <= 1'b1;
    v = 8'($urandom);
    mem_op(1'b1, 16'h12A5, 8'h3C, 4'h0);
    mem_op(1'b1, 16'h34A5, 8'hC3, 4'h2);
    mem_op(1'b0, 16'h12A5, 8'h3C, 4'h1);
    mem_op(1'b0, 16'h34A5, 8'hC3, 4'h0);
    mem_op(1'b1, 16'hBEEF, v, 4'h3);
    mem_op(1'b0, 16'hBEEF, v, 4'h0);
    wr(`REG_FUNC_SEL, 8'h00);
    @(posedge i_ref_clk);
    use_mem <= 1'b0;
    // Programming mode decode over all pin combinations, port six driven beforehand
    wr(5'h0E, 8'h00);
    vpp <= 2'h1;
    rst_pin_n <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(posedge i_ref_clk);
      {pr_ce_n, pr_oe_n, pr_pgm_n} <= 3'(n);
      {c, o, g} = 3'(n);
      pe = '{select: !c, prog_pulse: !c & o & !g, read_strobe: !o, inhibit: (!g & !o) | (g & o)};
      repeat (3) @(negedge i_ref_clk);
      `CMP(prog, 1'b1)
      `CMP(prom, pe)
      `CMP(pout[6].oe_n, 8'hFF)
    end
    rd(`REG_STATUS, 8'h01);
    @(posedge i_ref_clk);
    rst_pin_n <= 1'b1;
    settle();
    `CMP(prog, 1'b0)
    close_out();
  end
endmodule : port_pin_function_mux_tb
